// ---- include/coupler_regs.svh ----
`ifndef COUPLER_REGS_SVH
`define COUPLER_REGS_SVH

// Clock rate of mclk in MHz.
`define MCLK_MHZ 125

// Layout of the programming byte, common to both modes.
`define PB_ADDR_MSB 7
`define PB_ADDR_LSB 6
`define PB_SYNC_BIT 5
`define PB_SUPPLY_BIT 1

// Layout of the programming byte in asynchronous mode.
`define PB_DIV_MSB 4
`define PB_DIV_LSB 3
`define PB_SLOPE_BIT 2
`define PB_SPECIAL_BIT 0

// Layout of the programming byte in synchronous mode.
`define PB_SIO_BIT 4
`define PB_AUXA_BIT 3
`define PB_AUXB_BIT 2
`define PB_SCLK_BIT 0

// Layout of the returned status byte.
`define ST_AUXA_BIT 0
`define ST_AUXB_BIT 1
`define ST_FAULT_BIT 2
`define ST_DATA_BIT 3
`define ST_PRES_BIT 4

// Reset value of the stored programming byte: async, divide by one.
`define PB_RESET 8'h00

// Frame length in bits.
`define FRAME_BITS 4'h8

// Card detect filter time and each power-down step, in ns.
`define DET_FILT_NS 1000
`define PD_STEP_NS 1000
`define DET_FILT_CYC ((`DET_FILT_NS * `MCLK_MHZ + 999) / 1000)
`define PD_STEP_CYC ((`PD_STEP_NS * `MCLK_MHZ + 999) / 1000)

`endif

// ---- include/coupler_pkg.sv ----
`default_nettype none

package coupler_pkg;

    // Card clock division ratio as programmed.
    typedef enum logic [1:0] {
        DIV_1 = 2'b00,
        DIV_2 = 2'b01,
        DIV_4 = 2'b10,
        DIV_STOP = 2'b11
    } clk_div_t;

    // Card supply sequencing states.
    typedef enum logic [2:0] {
        PWR_OFF = 3'b000,
        PWR_RAMP = 3'b001,
        PWR_ON = 3'b010,
        PWR_DN_RST = 3'b011,
        PWR_DN_CLK = 3'b100,
        PWR_DN_IO = 3'b101
    } power_state_t;

    // Direction of the host-to-card serial translator.
    typedef enum logic [1:0] {
        XL_IDLE = 2'b00,
        XL_H2C = 2'b01,
        XL_C2H = 2'b10
    } xlat_state_t;

endpackage

`default_nettype wire

// ---- src/card_clock_div.sv ----
`include "coupler_regs.svh"
`default_nettype none

// Card clock divider working on the sampled level of the clock input.
module card_clock_div
    import coupler_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_in,
    input wire logic run,
    input wire clk_div_t div_sel,
    output logic card_clk
);

    // Previous sample of the clock input, for rising edge detection.
    logic clk_in_d_r;
    // Prescaler bit used for divide by four.
    logic pre_r;
    // Output flip-flop.
    logic out_r;
    // Rising edge of the sampled clock input.
    wire in_rise = clk_in & ~clk_in_d_r;

    // Toggling on rising edges only makes the divided outputs exactly
    // 50 percent, whatever the input duty cycle; divide by one passes the
    // input through and keeps its duty cycle.
    always_ff @(posedge mclk) begin
        clk_in_d_r <= clk_in;
        if (rst || !run) begin
            // Stopping always parks the clock low.
            pre_r <= 1'b0;
            out_r <= 1'b0;
        end else begin
            case (div_sel)
                DIV_1: out_r <= clk_in;
                DIV_2: begin
                    if (in_rise) begin
                        out_r <= ~out_r;
                    end
                end
                DIV_4: begin
                    if (in_rise) begin
                        pre_r <= ~pre_r;
                        if (pre_r) begin
                            out_r <= ~out_r;
                        end
                    end
                end
                default: out_r <= 1'b0;
            endcase
        end
    end

    assign card_clk = out_r;

endmodule

`default_nettype wire

// ---- src/smart_card_coupler_control.sv ----
`include "coupler_regs.svh"
`default_nettype none

module smart_card_coupler_control
    import coupler_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic spi_clk,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    input wire logic [1:0] chip_addr,
    input wire logic det_active_high,
    input wire logic host_pullup_select,
    output logic host_pullup_en,
    input wire logic host_io_in,
    output logic host_io_out,
    output logic host_io_oe,
    input wire logic card_io_in,
    output logic card_io_out,
    output logic card_io_oe,
    input wire logic host_rst_in,
    output logic card_rst_out,
    input wire logic clk_in,
    output logic card_clock_out,
    output logic clk_slope_fast,
    input wire logic card_presence_input,
    input wire logic vcc_low,
    input wire logic card_supply_uv,
    input wire logic card_supply_overload,
    input wire logic card_supply_ok,
    output logic card_supply,
    input wire logic aux_line_a_in,
    output logic aux_line_a_out,
    output logic aux_line_a_oe,
    input wire logic aux_line_b_in,
    output logic aux_line_b_out,
    output logic aux_line_b_oe,
    output logic int_n
);

    // Counter widths sized to hold the derived cycle counts.
    localparam int FILT_W = $clog2(`DET_FILT_CYC + 1);
    localparam int STEP_W = $clog2(`PD_STEP_CYC + 1);
    localparam logic [FILT_W-1:0] FILT_MAX = FILT_W'(`DET_FILT_CYC);
    localparam logic [STEP_W-1:0] STEP_MAX = STEP_W'(`PD_STEP_CYC);

    // Previous samples of the SPI clock and chip select.
    logic spi_clk_d_r;
    logic cs_n_d_r;
    // Receive shift register, transmit shift register and bit counter.
    logic [7:0] rx_r;
    logic [7:0] tx_r;
    logic [3:0] bit_cnt_r;
    // MISO data flip-flop.
    logic miso_r;
    // Stored programming byte and the flag that it addressed this chip.
    logic [7:0] prog_r;
    logic selected_r;
    // Filtered card detect level and its filter counter.
    logic det_f_r;
    logic [FILT_W-1:0] filt_cnt_r;
    // Presence as seen one cycle earlier, for edge events.
    logic present_d_r;
    // Overload as seen one cycle earlier.
    logic ovl_d_r;
    // Sticky flags: pending interrupt, overload fault, card undervoltage.
    logic int_pend_r;
    logic fault_r;
    logic uv_r;
    logic int_n_r;
    // Power sequencing state and its step timer.
    power_state_t pwr_r;
    power_state_t pwr_nxt;
    logic [STEP_W-1:0] step_cnt_r;
    // Translator direction state.
    xlat_state_t xl_r;
    xlat_state_t xl_nxt;
    // Registered pin drives.
    logic host_oe_r;
    logic card_oe_r;
    logic aux_a_oe_r;
    logic aux_b_oe_r;
    logic card_rst_r;
    logic card_clk_r;
    logic pullup_r;
    logic supply_r;
    // Output of the clock divider.
    logic div_clk;

    // Edges of the SPI clock and chip select; SPI timing never looks at
    // the card clock input, so both clocks may run at any ratio.
    wire spi_rise = spi_clk & ~spi_clk_d_r & ~cs_n;
    wire spi_fall = ~spi_clk & spi_clk_d_r & ~cs_n;
    wire cs_fall = ~cs_n & cs_n_d_r;
    wire cs_rise = cs_n & ~cs_n_d_r;

    // A frame is applied only if exactly eight bits came in.
    wire frame_done = cs_rise && (bit_cnt_r == `FRAME_BITS);
    // The address field picks one of four couplers.
    wire addr_hit = rx_r[`PB_ADDR_MSB:`PB_ADDR_LSB] == chip_addr;
    wire apply_own = frame_done && addr_hit;

    // Decoded fields of the stored programming byte.
    wire sync_mode = prog_r[`PB_SYNC_BIT];
    wire supply_req = prog_r[`PB_SUPPLY_BIT];
    wire special_mode = ~sync_mode & prog_r[`PB_SPECIAL_BIT];
    wire [1:0] div_bits = prog_r[`PB_DIV_MSB:`PB_DIV_LSB];
    wire clk_div_t div_sel = clk_div_t'(div_bits);

    // Presence regardless of detect switch polarity.
    wire present = ~(det_f_r ^ det_active_high);
    wire card_on = pwr_r == PWR_ON;
    // Active window: chip select low and this chip addressed.
    wire active = ~cs_n & selected_r;
    wire xlat_en = active & ~sync_mode & card_on;

    // Events that raise the interrupt.
    wire ev_insert = present & ~present_d_r;
    wire ev_remove = ~present & present_d_r;
    wire ev_ovl = card_supply_overload & ~ovl_d_r;

    // Aux readback: live pin in async mode, forced level in sync mode.
    // An open pin reads one through the external pull-up to card supply.
    wire aux_a_rd = sync_mode ? prog_r[`PB_AUXA_BIT] : aux_line_a_in;
    wire aux_b_rd = sync_mode ? prog_r[`PB_AUXB_BIT] : aux_line_b_in;
    // Bit 4: presence in normal mode, filtered detect level in special mode.
    wire st_pres = special_mode ? det_f_r : present;
    // Bit 3: card data in sync mode, card undervoltage in async mode.
    wire st_data = sync_mode ? card_io_in : uv_r;
    // The three top bits carry nothing and are sent as zero.
    wire [7:0] status_w = {3'b000, st_pres, st_data, fault_r,
                           aux_b_rd, aux_a_rd};

    // Sample the SPI clock and chip select for edge detection.
    always_ff @(posedge mclk) begin
        spi_clk_d_r <= spi_clk;
        cs_n_d_r <= cs_n;
    end

    // Receive side: shift MOSI on rising SPI clock edges and count bits.
    // The count saturates above eight so a long frame is thrown away.
    always_ff @(posedge mclk) begin
        if (rst || cs_fall) begin
            bit_cnt_r <= 4'h0;
            rx_r <= 8'h00;
        end else if (spi_rise) begin
            rx_r <= {rx_r[6:0], mosi};
            if (bit_cnt_r <= `FRAME_BITS) begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
        end
    end

    // Transmit side: status is captured at the frame start and shifted out
    // MSB first on falling SPI clock edges of the same frame.
    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_r <= 8'h00;
            miso_r <= 1'b0;
        end else if (cs_fall) begin
            tx_r <= status_w;
            miso_r <= status_w[7];
        end else if (spi_fall) begin
            tx_r <= {tx_r[6:0], 1'b0};
            miso_r <= tx_r[6];
        end
    end

    // Apply the programming byte at the end of a complete frame; a frame
    // for another coupler deselects this one but keeps its settings.
    always_ff @(posedge mclk) begin
        if (rst) begin
            prog_r <= `PB_RESET;
            selected_r <= 1'b0;
        end else if (frame_done) begin
            selected_r <= addr_hit;
            if (addr_hit) begin
                prog_r <= rx_r;
            end
        end
    end

    // Card detect filter: a new level is taken only after it has been
    // stable for the filter time, which rejects spikes on the pin.
    always_ff @(posedge mclk) begin
        if (rst) begin
            det_f_r <= 1'b1;
            filt_cnt_r <= '0;
        end else if (card_presence_input == det_f_r) begin
            filt_cnt_r <= '0;
        end else if (filt_cnt_r == FILT_MAX) begin
            det_f_r <= card_presence_input;
            filt_cnt_r <= '0;
        end else begin
            filt_cnt_r <= filt_cnt_r + 1'b1;
        end
    end

    // Sticky flags: a new event in the clearing cycle wins over the
    // clear. A frame to this chip counts as the host having read them.
    always_ff @(posedge mclk) begin
        if (rst) begin
            present_d_r <= 1'b0;
            ovl_d_r <= 1'b0;
            int_pend_r <= 1'b0;
            fault_r <= 1'b0;
            uv_r <= 1'b0;
        end else begin
            present_d_r <= present;
            ovl_d_r <= card_supply_overload;
            int_pend_r <= ev_insert | ev_remove | ev_ovl |
                          (int_pend_r & ~apply_own);
            fault_r <= card_supply_overload | (fault_r & ~apply_own);
            // Undervoltage only flags; sequencing is left to the host.
            uv_r <= card_supply_uv | (uv_r & ~apply_own);
        end
    end

    // Interrupt pin: low while an event is pending, forced high while
    // the chip's own supply is below its threshold.
    always_ff @(posedge mclk) begin
        if (rst) begin
            int_n_r <= 1'b1;
        end else begin
            int_n_r <= vcc_low | ~int_pend_r;
        end
    end

    // Next state of the card supply sequence. Overload and removal both
    // start the three power-down steps; reset, clock and I/O all drop together at the first.
    always_comb begin
        pwr_nxt = pwr_r;
        case (pwr_r)
            PWR_OFF: begin
                if (supply_req && present && !fault_r) begin
                    pwr_nxt = PWR_RAMP;
                end
            end
            PWR_RAMP: begin
                if (card_supply_overload || !supply_req || !present) begin
                    pwr_nxt = PWR_DN_RST;
                end else if (card_supply_ok) begin
                    pwr_nxt = PWR_ON;
                end
            end
            PWR_ON: begin
                if (card_supply_overload || !supply_req || !present) begin
                    pwr_nxt = PWR_DN_RST;
                end
            end
            PWR_DN_RST: begin
                if (step_cnt_r == STEP_MAX) begin
                    pwr_nxt = PWR_DN_CLK;
                end
            end
            PWR_DN_CLK: begin
                if (step_cnt_r == STEP_MAX) begin
                    pwr_nxt = PWR_DN_IO;
                end
            end
            PWR_DN_IO: begin
                if (step_cnt_r == STEP_MAX) begin
                    pwr_nxt = PWR_OFF;
                end
            end
            default: pwr_nxt = PWR_OFF;
        endcase
    end

    // Supply state and the step timer, which restarts at each new state.
    always_ff @(posedge mclk) begin
        if (rst) begin
            pwr_r <= PWR_OFF;
            step_cnt_r <= '0;
        end else begin
            pwr_r <= pwr_nxt;
            step_cnt_r <= (pwr_nxt != pwr_r) ? '0 : step_cnt_r + 1'b1;
        end
    end

    // Converter enable: on through the sequence, cut at once on overload
    // rather than waiting for the power-down steps to finish.
    always_ff @(posedge mclk) begin
        if (rst) begin
            supply_r <= 1'b0;
        end else begin
            supply_r <= (pwr_nxt != PWR_OFF) && !card_supply_overload &&
                        !fault_r;
        end
    end

    // Translator direction: whichever side pulls low first owns the
    // line until it releases, so the two drivers never latch each other.
    always_comb begin
        xl_nxt = xl_r;
        case (xl_r)
            XL_IDLE: begin
                if (!host_io_in) begin
                    xl_nxt = XL_H2C;
                end else if (!card_io_in) begin
                    xl_nxt = XL_C2H;
                end
            end
            XL_H2C: begin
                if (host_io_in) begin
                    xl_nxt = XL_IDLE;
                end
            end
            XL_C2H: begin
                if (card_io_in) begin
                    xl_nxt = XL_IDLE;
                end
            end
            default: xl_nxt = XL_IDLE;
        endcase
        if (!xlat_en) begin
            xl_nxt = XL_IDLE;
        end
    end

    // Translator state register.
    always_ff @(posedge mclk) begin
        if (rst) begin
            xl_r <= XL_IDLE;
        end else begin
            xl_r <= xl_nxt;
        end
    end

    // Card I/O drive: pulled low while unpowered or starting, relayed
    // from the host in async mode, from the stored bit in sync mode.
    always_ff @(posedge mclk) begin
        if (rst) begin
            card_oe_r <= 1'b1;
            host_oe_r <= 1'b0;
        end else begin
            host_oe_r <= xl_nxt == XL_C2H;
            if (!card_on) begin
                card_oe_r <= 1'b1;
            end else if (sync_mode) begin
                // Host line stays released; data goes through status.
                card_oe_r <= active & ~prog_r[`PB_SIO_BIT];
            end else begin
                card_oe_r <= xl_nxt == XL_H2C;
            end
        end
    end

    // Aux lines: open-drain outputs in sync mode, inputs in async mode.
    always_ff @(posedge mclk) begin
        if (rst) begin
            aux_a_oe_r <= 1'b0;
            aux_b_oe_r <= 1'b0;
        end else begin
            aux_a_oe_r <= card_on & sync_mode & ~prog_r[`PB_AUXA_BIT];
            aux_b_oe_r <= card_on & sync_mode & ~prog_r[`PB_AUXB_BIT];
        end
    end

    // Card reset follows the host only while powered and selected.
    always_ff @(posedge mclk) begin
        if (rst) begin
            card_rst_r <= 1'b0;
        end else begin
            card_rst_r <= card_on & active & host_rst_in;
        end
    end

    // Card clock: the divider in async mode, the stored bit in sync
    // mode, and low outside the powered state.
    always_ff @(posedge mclk) begin
        if (rst) begin
            card_clk_r <= 1'b0;
        end else if (!card_on) begin
            card_clk_r <= 1'b0;
        end else if (sync_mode) begin
            card_clk_r <= prog_r[`PB_SCLK_BIT];
        end else begin
            card_clk_r <= div_clk;
        end
    end

    // Host pull-up: pin must allow it and this chip must be selected.
    always_ff @(posedge mclk) begin
        if (rst) begin
            pullup_r <= 1'b0;
        end else begin
            pullup_r <= host_pullup_select & selected_r;
        end
    end

    // Divider runs only while powered in async mode and not stopped.
    card_clock_div u_div (
        .mclk(mclk),
        .rst(rst),
        .clk_in(clk_in),
        .run(card_on & ~sync_mode & (div_sel != DIV_STOP)),
        .div_sel(div_sel),
        .card_clk(div_clk)
    );

    // Open-drain pins only ever drive low.
    assign host_io_out = 1'b0;
    assign card_io_out = 1'b0;
    assign aux_line_a_out = 1'b0;
    assign aux_line_b_out = 1'b0;
    assign host_io_oe = host_oe_r;
    assign card_io_oe = card_oe_r;
    assign aux_line_a_oe = aux_a_oe_r;
    assign aux_line_b_oe = aux_b_oe_r;
    // Only the selected coupler drives the shared MISO line.
    assign miso = miso_r;
    assign miso_oe = active;
    assign host_pullup_en = pullup_r;
    assign card_rst_out = card_rst_r;
    assign card_clock_out = card_clk_r;
    // Slope is forced low in sync frames, which reuse that bit.
    assign clk_slope_fast = prog_r[`PB_SLOPE_BIT] & ~sync_mode;
    assign card_supply = supply_r;
    assign int_n = int_n_r;

endmodule

`default_nettype wire

// ---- verification/coupler_props.sv ----
`default_nettype none

// Watches the coupler's pins; one clock domain, so defaults are used.
module coupler_props (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic miso_oe,
    input wire logic host_pullup_select,
    input wire logic host_pullup_en,
    input wire logic host_io_oe,
    input wire logic card_io_oe,
    input wire logic card_clock_out,
    input wire logic clk_slope_fast,
    input wire logic card_supply_overload,
    input wire logic card_supply,
    input wire logic vcc_low,
    input wire logic card_rst_out,
    input wire logic int_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_vcc_int_high: assert property (vcc_low |=> int_n)
        else $error("int_n low while own supply is low");
    a_pullup_off: assert property (
        !host_pullup_select |=> !host_pullup_en)
        else $error("pull-up on with select low");
    a_cs_high_oe: assert property (cs_n |-> !miso_oe)
        else $error("miso driven with chip select high");
    a_cs_high_io: assert property (cs_n [*2] |-> !host_io_oe)
        else $error("host line driven outside a frame");
    // Two cycles of no supply leave room for the registered clock output.
    a_clk_off: assert property (!card_supply [*2] |-> !card_clock_out)
        else $error("card clock runs without supply");
    a_io_off: assert property (!card_supply [*2] |-> card_io_oe)
        else $error("card line not held low without supply");
    a_ovl_supply: assert property (
        card_supply_overload |-> ##[1:2] !card_supply)
        else $error("supply stays on under overload");
    a_ovl_int: assert property (
        $rose(card_supply_overload) ##0 !vcc_low [*5] |-> !int_n)
        else $error("no interrupt after overload");
    // Settings may only move once the frame has closed.
    a_slope_frame: assert property (
        $changed(clk_slope_fast) |-> $past(rst) || cs_n)
        else $error("slope changed inside a frame");
    // Card reset is only passed on inside a frame.
    a_rst_cs_off: assert property (cs_n |=> !card_rst_out)
        else $error("card reset driven with chip select high");
endmodule

bind smart_card_coupler_control coupler_props u_props (
    .mclk, .rst, .cs_n, .miso_oe, .host_pullup_select, .host_pullup_en,
    .host_io_oe, .card_io_oe, .card_clock_out, .clk_slope_fast,
    .card_supply_overload, .card_supply, .vcc_low, .int_n, .card_rst_out);

`default_nettype wire

// ---- verification/spi_host.sv ----
`default_nettype none

// Host side of the SPI frame: mode 0, MSB first, idle clock low.
module spi_host (
    input wire logic mclk,
    input wire logic miso,
    output logic cs_n,
    output logic spi_clk,
    output logic mosi
);
    timeunit 1ns;
    timeprecision 1ps;

    // Lines idle with chip select high and the clock standing still.
    initial begin
        cs_n = 1'b1;
        spi_clk = 1'b0;
        mosi = 1'b0;
    end

    task tk(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    // One frame of n bits; the address travels in the top bits.
    task automatic xfer(input int n, input logic [7:0] tx,
                        output logic [7:0] rx);
        rx = 8'h00;
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            mosi = tx[7 - i];
            tk(3);
            rx = {rx[6:0], miso};
            spi_clk = 1'b1;
            tk(2);
            spi_clk = 1'b0;
            tk(1);
        end
        tk(2);
        cs_n = 1'b1;
        // A released data line must not keep its last value.
        mosi = ~mosi;
        tk(3);
        rx = rx & 8'h1F;
    endtask

    // Chip select low with no clock, for a card transaction.
    task cs_hold;
        cs_n = 1'b0;
        tk(2);
    endtask

    // Ends a clockless frame, which carries no bits and is not applied.
    task cs_release;
        cs_n = 1'b1;
        tk(3);
    endtask
endmodule

`default_nettype wire

// ---- verification/testbench.sv ----
`default_nettype none

`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk, rst = 1'b1, host_pullup_select = 1'b0, clk_in;
    logic card_presence_input = 1'b1, vcc_low = 1'b0;
    logic card_supply_overload = 1'b0, card_supply_ok = 1'b0;
    logic gnd_a = 1'b0, gnd_b = 1'b1; // Pins held at ground by the card.
    logic host_pull = 1'b0; // Host pulls its serial line low.
    logic [1:0] chip_addr = 2'b01;
    logic det_active_high = 1'b0, host_rst_in = 1'b1, card_supply_uv = 1'b0;
    wire cs_n, spi_clk, mosi, miso, miso_oe, host_pullup_en, host_io_out;
    wire host_io_oe, card_io_out, card_io_oe, card_rst_out, card_supply;
    wire card_clock_out, clk_slope_fast, aux_line_a_out, aux_line_a_oe;
    wire aux_line_b_out, aux_line_b_oe, int_n;
    // Open-drain lines with pull-ups; miso has a pull-down when released.
    wire host_io_in = ~(host_io_oe | host_pull);
    wire card_io_in = ~card_io_oe;
    wire aux_line_a_in = ~(aux_line_a_oe | gnd_a);
    wire aux_line_b_in = ~(aux_line_b_oe | gnd_b);
    wire miso_w = miso_oe & miso;
    int fail_count = 0, compares = 0, cyc = 0, h, l;
    logic [7:0] s;

    smart_card_coupler_control u_dut (.mclk, .rst, .cs_n, .spi_clk, .mosi,
        .miso, .miso_oe, .chip_addr, .det_active_high, .host_pullup_select,
        .host_pullup_en, .host_io_in, .host_io_out, .host_io_oe, .card_io_in,
        .card_io_out, .card_io_oe, .host_rst_in, .card_rst_out, .clk_in,
        .card_clock_out, .clk_slope_fast, .card_presence_input, .vcc_low,
        .card_supply_uv, .card_supply_overload, .card_supply_ok,
        .card_supply, .aux_line_a_in, .aux_line_a_out, .aux_line_a_oe,
        .aux_line_b_in, .aux_line_b_out, .aux_line_b_oe, .int_n);

    spi_host u_host (.mclk, .miso(miso_w), .cs_n, .spi_clk, .mosi);

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // Card clock source: 8 mclk period, only 3 high, to stress the duty.
    // It moves just after an mclk edge, like every other input.
    initial begin
        clk_in = 1'b0;
        forever begin
            repeat (5) @(posedge mclk);
            #1;
            clk_in = 1'b1;
            repeat (3) @(posedge mclk);
            #1;
            clk_in = 1'b0;
        end
    end

    task tk(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask

    task send(input logic [7:0] b);
        u_host.xfer(8, b, s);
    endtask

    // Counts the cycles of one high and one low phase of the card clock.
    task meas(output int hi, output int lo);
        hi = 0;
        lo = 0;
        for (int w = 0; w < 100 && card_clock_out !== 1'b0; w++) tk(1);
        for (int w = 0; w < 100 && card_clock_out !== 1'b1; w++) tk(1);
        while (card_clock_out === 1'b1 && hi < 100) begin
            hi++;
            tk(1);
        end
        while (card_clock_out === 1'b0 && lo < 100) begin
            lo++;
            tk(1);
        end
    endtask

    task results;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Cuts a hang short; the whole run needs a few thousand cycles.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            results;
        end
    end

    initial begin
        tk(16);
        rst = 1'b0;
        tk(2);
        send(8'h40);
        `CHK(s, 8'h00)
        send(8'h80);
        `CHK(s, 8'h01)
        host_pullup_select = 1'b1;
        send(8'h40);
        `CHK(host_pullup_en, 1'b1)
        send(8'h80);
        `CHK(host_pullup_en, 1'b0)
        // Seven bits that would select this chip with a fast slope.
        u_host.xfer(7, 8'h88, s);
        `CHK(clk_slope_fast, 1'b0)
        send(8'h44);
        `CHK(clk_slope_fast, 1'b1)
        card_presence_input = 1'b0;
        tk(200);
        `CHK(int_n, 1'b0)
        send(8'h46);
        `CHK(s, 8'h11)
        `CHK(int_n, 1'b1)
        tk(20);
        `CHK(card_supply, 1'b1)
        `CHK(card_clock_out, 1'b0)
        card_supply_ok = 1'b1;
        for (int d = 0; d < 3; d++) begin
            send(8'h46 | 8'(d << 3));
            tk(40);
            meas(h, l);
            `CHK(h, d == 0 ? 3 : 8 * d)
            `CHK(l, d == 0 ? 5 : 8 * d)
        end
        // Host pulls its line inside a clockless frame: relayed to the card.
        u_host.cs_hold();
        host_pull = 1'b1;
        tk(3);
        `CHK(card_io_oe, 1'b1)
        `CHK(card_rst_out, 1'b1)
        host_pull = 1'b0;
        tk(3);
        `CHK(card_io_oe, 1'b0)
        u_host.cs_release();
        card_supply_uv = 1'b1;
        tk(2);
        card_supply_uv = 1'b0;
        `CHK(card_supply, 1'b1)
        send(8'h46);
        `CHK(s, 8'h19)
        card_supply_overload = 1'b1;
        tk(3);
        `CHK(card_supply, 1'b0)
        `CHK(int_n, 1'b0)
        card_supply_overload = 1'b0;
        tk(400);
        send(8'h46);
        `CHK(s, 8'h15)
        card_presence_input = 1'b1;
        tk(200);
        `CHK(int_n, 1'b0)
        vcc_low = 1'b1;
        tk(2);
        `CHK(int_n, 1'b1)
        vcc_low = 1'b0;
        gnd_a = 1'b1;
        send(8'h78);
        send(8'h78);
        `CHK(s, 8'h01)
        // Flipped switch polarity: the high pin now means a card.
        det_active_high = 1'b1;
        tk(3);
        `CHK(int_n, 1'b0)
        send(8'h40);
        `CHK(s, 8'h11)
        det_active_high = 1'b0;
        send(8'h41);
        `CHK(s, 8'h00)
        send(8'h41);
        `CHK(s, 8'h10)
        results;
    end
endmodule

`default_nettype wire
